// ---- sdlc_lane_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdlc_lane_bank
  import sdlc_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h00000000,
  parameter logic [31:0] WR_MASK = 32'hFFFFFFFF
) (
  // clock and sticky reset
  input wire logic aclk,
  input wire logic sticky_resetn,
  // write side
  input wire logic wr_en,
  input wire logic [4:0] lane_sel,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // last written value and per-lane copies
  output logic [31:0] last_val,
  output logic [SDLC_LANES*32-1:0] lane_val
);
  logic [31:0] last_r;
  logic [31:0] last_nxt;
  logic [31:0] merged;
  logic [31:0] bmask;

  // byte lane merge of the written word
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bmask[b*8 +: 8] = wstrb[b] ? 8'hFF : 8'h00;
    end
    merged = (last_r & ~bmask) | (wdata & bmask & WR_MASK);
    last_nxt = wr_en ? merged : last_r;
  end

  // readback ignores lane selection
  always_ff @(posedge aclk) begin
    if (!sticky_resetn) begin
      last_r <= RST_VAL;
    end else begin
      last_r <= last_nxt;
    end
  end
  assign last_val = last_r;

  // one stored copy per lane, kept over software resets
  genvar g;
  generate
    for (g = 0; g < SDLC_LANES; g++) begin : g_lane
      logic [31:0] copy_r;
      logic [31:0] copy_nxt;
      logic hit;
      always_comb begin
        hit = wr_en && ((lane_sel == SDLC_LANE_ALL) || (lane_sel == 5'(g)));
        copy_nxt = hit ? ((copy_r & ~bmask) | (wdata & bmask & WR_MASK)) : copy_r;
      end
      always_ff @(posedge aclk) begin
        if (!sticky_resetn) begin
          copy_r <= RST_VAL;
        end else begin
          copy_r <= copy_nxt;
        end
      end
      assign lane_val[g*32 +: 32] = copy_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- sdlc_pkg.sv ----
package sdlc_pkg;
  // =========================================
  // register map (byte addresses, own choice)
  localparam logic [7:0] SDLC_QUAD_CTL_OFS = 8'h00;
  localparam logic [7:0] SDLC_TXL_CTL_OFS = 8'h04;
  localparam logic [7:0] SDLC_STATUS_OFS = 8'h08;
  localparam logic [7:0] SDLC_TXL_CTL_SECOND_OFS = 8'h0C;
  localparam logic [7:0] SDLC_RXL_CTL_OFS = 8'h10;
  localparam logic [7:0] SDLC_RXEQ_CTL_OFS = 8'h14;
  // =========================================
  // quad control fields
  localparam int SDLC_LANE_SEL_LSB = 0;
  localparam int SDLC_LANE_SEL_W = 5;
  localparam int SDLC_PDN_BIT = 5;
  localparam logic [4:0] SDLC_LANE_SEL_RST = 5'h10;
  localparam logic [4:0] SDLC_LANE_ALL = 5'h10;
  localparam logic [4:0] SDLC_LANE_MAX = 5'h03;
  localparam int SDLC_LANES = 4;
  // =========================================
  // tx lane control fields
  localparam int SDLC_CD1_LSB = 0;
  localparam int SDLC_CD2L_LSB = 2;
  localparam int SDLC_CD2H_LSB = 4;
  localparam int SDLC_EQ1_LSB = 8;
  localparam logic [31:0] SDLC_TXL_MASK = 32'h0000033F;
  localparam logic [31:0] SDLC_TXL_RST = 32'h00000237;
  localparam logic [31:0] SDLC_LANE_REG_RST = 32'h00000000;
  // =========================================
  // axi responses
  localparam logic [1:0] SDLC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDLC_RESP_SLVERR = 2'h2;
  // =========================================
  // training request states
  typedef enum logic [1:0] {
    SDLC_ST_ON = 2'b00,
    SDLC_ST_OFF = 2'b01,
    SDLC_ST_INIT = 2'b11
  } sdlc_pwr_t;
endpackage

// ---- sdlc_regs.sv ----
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - lane target picks which lane copy updates
// - codes 0-3 single lane, 0x10 all; reset 0x10
// - lane register reads return last written value
// - power-down bit set switches clock multiplier off
// - power-down forces training machine to Detect
// - clearing power-down reinitialises, then training restarts
// - power-down ignored when quad already off, except while reinitialising
// - lane copies survive software resets
// - bits 1:0 de-emphasis, gen1 full swing
// - low swing disables all coarse de-emphasis
// - bits 3:2 de-emphasis, gen2 at -3.5dB
// - bits 5:4 de-emphasis, gen2 at -6.0dB
// - bits 9:8 tx equalize, gen1 at -3.5dB
// - low swing when low_swing_enable equals one
module sdlc_regs
  import sdlc_pkg::*;
(
  // clock, software reset, sticky reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sticky_resetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port state from link layer (async)
  input wire logic low_swing_enable,
  input wire logic deemph_level_select,
  input wire logic gen2_rate,
  input wire logic quad_off_other,
  input wire logic cmu_ready,
  // quad and training controls
  output logic clock_multiplier_unit_on,
  output logic ltssm_force_detect,
  output logic ltssm_start_training,
  // per-lane effective analog controls
  output logic [SDLC_LANES*2-1:0] lane_deemph,
  output logic [SDLC_LANES-1:0] lane_deemph_en,
  output logic [SDLC_LANES*2-1:0] lane_tx_eq
);
  // =========================================
  // synchronised inputs
  logic lse_s;
  logic sde_s;
  logic gen2_s;
  logic qoff_s;
  logic cmu_s;
  sdlc_sync u_sync_lse (.aclk(aclk), .aresetn(aresetn), .din(low_swing_enable), .dout(lse_s));
  sdlc_sync u_sync_sde (.aclk(aclk), .aresetn(aresetn), .din(deemph_level_select), .dout(sde_s));
  sdlc_sync u_sync_gen (.aclk(aclk), .aresetn(aresetn), .din(gen2_rate), .dout(gen2_s));
  sdlc_sync u_sync_qof (.aclk(aclk), .aresetn(aresetn), .din(quad_off_other), .dout(qoff_s));
  sdlc_sync u_sync_cmu (.aclk(aclk), .aresetn(aresetn), .din(cmu_ready), .dout(cmu_s));

  // =========================================
  // axi write channel state
  logic aw_hold_r;
  logic aw_hold_nxt;
  logic [7:0] aw_addr_r;
  logic [7:0] aw_addr_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0] w_strb_r;
  logic [3:0] w_strb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic wr_fire;
  logic wr_hit;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  // capture address and data in either order, answer after both
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? SDLC_RESP_OKAY : SDLC_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= SDLC_RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // =========================================
  // decode
  logic wr_quad;
  logic wr_txl;
  logic wr_txl2;
  logic wr_rxl;
  logic wr_rxeq;
  always_comb begin
    wr_quad = wr_fire && (aw_addr_r == SDLC_QUAD_CTL_OFS);
    wr_txl = wr_fire && (aw_addr_r == SDLC_TXL_CTL_OFS);
    wr_txl2 = wr_fire && (aw_addr_r == SDLC_TXL_CTL_SECOND_OFS);
    wr_rxl = wr_fire && (aw_addr_r == SDLC_RXL_CTL_OFS);
    wr_rxeq = wr_fire && (aw_addr_r == SDLC_RXEQ_CTL_OFS);
    wr_hit = wr_quad || wr_txl || wr_txl2 || wr_rxl || wr_rxeq || (aw_addr_r == SDLC_STATUS_OFS);
  end

  // =========================================
  // quad control register (sticky)
  logic [4:0] lane_sel_r;
  logic [4:0] lane_sel_nxt;
  logic pdn_r;
  logic pdn_nxt;
  always_comb begin
    lane_sel_nxt = lane_sel_r;
    pdn_nxt = pdn_r;
    if (wr_quad && w_strb_r[0]) begin
      lane_sel_nxt = w_data_r[SDLC_LANE_SEL_LSB +: SDLC_LANE_SEL_W];
      pdn_nxt = w_data_r[SDLC_PDN_BIT];
    end
  end
  always_ff @(posedge aclk) begin
    if (!sticky_resetn) begin
      lane_sel_r <= SDLC_LANE_SEL_RST;
      pdn_r <= 1'b0;
    end else begin
      lane_sel_r <= lane_sel_nxt;
      pdn_r <= pdn_nxt;
    end
  end

  // =========================================
  // lane banks
  logic [31:0] txl_last;
  logic [31:0] txl2_last;
  logic [31:0] rxl_last;
  logic [31:0] rxeq_last;
  logic [SDLC_LANES*32-1:0] txl_lanes;
  sdlc_lane_bank #(.RST_VAL(SDLC_TXL_RST), .WR_MASK(SDLC_TXL_MASK)) u_txl (
    .aclk(aclk), .sticky_resetn(sticky_resetn), .wr_en(wr_txl), .lane_sel(lane_sel_r),
    .wdata(w_data_r), .wstrb(w_strb_r), .last_val(txl_last), .lane_val(txl_lanes));
  sdlc_lane_bank #(.RST_VAL(SDLC_LANE_REG_RST)) u_txl2 (
    .aclk(aclk), .sticky_resetn(sticky_resetn), .wr_en(wr_txl2), .lane_sel(lane_sel_r),
    .wdata(w_data_r), .wstrb(w_strb_r), .last_val(txl2_last), .lane_val());
  sdlc_lane_bank #(.RST_VAL(SDLC_LANE_REG_RST)) u_rxl (
    .aclk(aclk), .sticky_resetn(sticky_resetn), .wr_en(wr_rxl), .lane_sel(lane_sel_r),
    .wdata(w_data_r), .wstrb(w_strb_r), .last_val(rxl_last), .lane_val());
  sdlc_lane_bank #(.RST_VAL(SDLC_LANE_REG_RST)) u_rxeq (
    .aclk(aclk), .sticky_resetn(sticky_resetn), .wr_en(wr_rxeq), .lane_sel(lane_sel_r),
    .wdata(w_data_r), .wstrb(w_strb_r), .last_val(rxeq_last), .lane_val());

  // =========================================
  // power-down and training control
  sdlc_pwr_t pst_r;
  sdlc_pwr_t pst_nxt;
  logic start_r;
  logic start_nxt;
  always_comb begin
    pst_nxt = pst_r;
    start_nxt = 1'b0;
    unique case (pst_r)
      SDLC_ST_ON: begin
        if (pdn_r && !qoff_s) begin
          pst_nxt = SDLC_ST_OFF;
        end
      end
      SDLC_ST_OFF: begin
        if (!pdn_r) begin
          pst_nxt = SDLC_ST_INIT;
        end
      end
      SDLC_ST_INIT: begin
        if (pdn_r) begin
          pst_nxt = SDLC_ST_OFF;
        end else if (cmu_s) begin
          pst_nxt = SDLC_ST_ON;
          start_nxt = 1'b1;
        end
      end
      default: begin
        pst_nxt = SDLC_ST_ON;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pst_r <= SDLC_ST_ON;
      start_r <= 1'b0;
    end else begin
      pst_r <= pst_nxt;
      start_r <= start_nxt;
    end
  end
  assign clock_multiplier_unit_on = (pst_r == SDLC_ST_ON) || (pst_r == SDLC_ST_INIT);
  assign ltssm_force_detect = (pst_r == SDLC_ST_OFF) || (pst_r == SDLC_ST_INIT);
  assign ltssm_start_training = start_r;

  // =========================================
  // effective per-lane de-emphasis and equalization
  logic [SDLC_LANES*2-1:0] deemph_r;
  logic [SDLC_LANES*2-1:0] deemph_nxt;
  logic [SDLC_LANES-1:0] deen_r;
  logic [SDLC_LANES-1:0] deen_nxt;
  logic [SDLC_LANES*2-1:0] eq_r;
  logic [SDLC_LANES*2-1:0] eq_nxt;
  always_comb begin
    for (int l = 0; l < SDLC_LANES; l++) begin
      if (!gen2_s) begin
        deemph_nxt[l*2 +: 2] = txl_lanes[l*32 + SDLC_CD1_LSB +: 2];
      end else if (!sde_s) begin
        deemph_nxt[l*2 +: 2] = txl_lanes[l*32 + SDLC_CD2L_LSB +: 2];
      end else begin
        deemph_nxt[l*2 +: 2] = txl_lanes[l*32 + SDLC_CD2H_LSB +: 2];
      end
      deen_nxt[l] = !lse_s;
      eq_nxt[l*2 +: 2] = (!gen2_s && !sde_s) ? txl_lanes[l*32 + SDLC_EQ1_LSB +: 2] : 2'h0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deemph_r <= '0;
      deen_r <= '0;
      eq_r <= '0;
    end else begin
      deemph_r <= deemph_nxt;
      deen_r <= deen_nxt;
      eq_r <= eq_nxt;
    end
  end
  assign lane_deemph = deemph_r;
  assign lane_deemph_en = deen_r;
  assign lane_tx_eq = eq_r;

  // =========================================
  // axi read channel
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  assign s_axi_arready = !rvalid_r;
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = SDLC_RESP_OKAY;
      unique case (s_axi_araddr)
        SDLC_QUAD_CTL_OFS: rdata_nxt = {26'h0, pdn_r, lane_sel_r};
        SDLC_TXL_CTL_OFS: rdata_nxt = txl_last;
        SDLC_TXL_CTL_SECOND_OFS: rdata_nxt = txl2_last;
        SDLC_RXL_CTL_OFS: rdata_nxt = rxl_last;
        SDLC_RXEQ_CTL_OFS: rdata_nxt = rxeq_last;
        SDLC_STATUS_OFS: rdata_nxt = {27'h0, qoff_s, ltssm_force_detect, clock_multiplier_unit_on,
                                      lse_s, gen2_s};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = SDLC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= SDLC_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// ---- sdlc_regs_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// =========================================
// bus and power checks at the block ports
module sdlc_regs_chk
  import sdlc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  // port state and quad outputs
  input wire logic low_swing_enable,
  input wire logic quad_off_other,
  input wire logic clock_multiplier_unit_on,
  input wire logic ltssm_force_detect,
  input wire logic ltssm_start_training,
  input wire logic [SDLC_LANES-1:0] lane_deemph_en
);
  // one clock domain, software reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  off_detect_a: assert property (!clock_multiplier_unit_on |-> ltssm_force_detect)
    else $error("quad off without detect");
  start_pulse_a: assert property (ltssm_start_training |=> !ltssm_start_training)
    else $error("training start longer than one cycle");
  start_after_a: assert property (ltssm_start_training |-> $past(ltssm_force_detect))
    else $error("training start without prior detect");
  off_other_a: assert property (quad_off_other [*8] ##0 clock_multiplier_unit_on |=> clock_multiplier_unit_on)
    else $error("power down acted on quad already off");
  low_swing_a: assert property (low_swing_enable [*8] |-> lane_deemph_en == 4'h0)
    else $error("de-emphasis on in low swing");
endmodule

bind sdlc_regs sdlc_regs_chk i_sdlc_regs_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .low_swing_enable, .quad_off_other,
  .clock_multiplier_unit_on, .ltssm_force_detect, .ltssm_start_training, .lane_deemph_en);
`default_nettype wire

// ---- sdlc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdlc_sync
  import sdlc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // async level in, filtered level out
  input wire logic din,
  output logic dout
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic dout_r;
  logic dout_nxt;

  // shift and accept when stages two and three agree
  always_comb begin
    sh_nxt = {sh_r[1:0], din};
    dout_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : dout_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_r <= 3'h0;
      dout_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign dout = dout_r;
endmodule
`default_nettype wire

// ---- tb_sdlc_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
// =========================================
// bench for the lane control registers
module tb_sdlc_regs;
  import sdlc_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, sticky_resetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic low_swing_enable = 1'h0, deemph_level_select = 1'h0, gen2_rate = 1'h0;
  logic quad_off_other = 1'h0, cmu_ready = 1'h1;
  logic clock_multiplier_unit_on, ltssm_force_detect, ltssm_start_training;
  logic [SDLC_LANES*2-1:0] lane_deemph, lane_tx_eq;
  logic [SDLC_LANES-1:0] lane_deemph_en;
  logic [7:0] ed;
  int errors = 0, n_checks = 0;

  // 100 ns clock
  always #50 aclk = ~aclk;

  sdlc_regs i_sdlc_regs (.aclk, .aresetn, .sticky_resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .low_swing_enable, .deemph_level_select, .gen2_rate, .quad_off_other, .cmu_ready,
    .clock_multiplier_unit_on, .ltssm_force_detect, .ltssm_start_training, .lane_deemph, .lane_deemph_en,
    .lane_tx_eq);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bus write, response code left in rr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask

  // bus read, data in rv and code in rr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
    chk(rr, SDLC_RESP_OKAY);
  endtask

  // lets the input synchronisers catch up
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask

  task automatic outs(input logic [7:0] d, input logic [7:0] q);
    settle;
    chk(lane_deemph, d);
    chk(lane_tx_eq, q);
  endtask

  task automatic t_defaults;
    rchk(SDLC_QUAD_CTL_OFS, 32'h10);
    rchk(SDLC_TXL_CTL_OFS, 32'h237);
    rchk(SDLC_STATUS_OFS, 32'h4);
    outs(8'hFF, 8'hAA);
    chk(lane_deemph_en, 4'hF);
  endtask

  // rate and level select each coarse field
  task automatic t_modes;
    logic [7:0] d[4] = '{8'h55, 8'h55, 8'hAA, 8'hFF};
    wr(SDLC_TXL_CTL_OFS, 32'h139);
    chk(rr, SDLC_RESP_OKAY);
    rchk(SDLC_TXL_CTL_OFS, 32'h139);
    for (int m = 0; m < 4; m++) begin
      {gen2_rate, deemph_level_select} <= m[1:0];
      outs(d[m], (m == 0) ? 8'h55 : 8'h00);
    end
    low_swing_enable <= 1'h1;
    settle;
    chk(lane_deemph_en, 4'h0);
    {low_swing_enable, gen2_rate, deemph_level_select} <= 3'h0;
  endtask

  // only defined lane codes are used
  task automatic t_lanes;
    ed = 8'h55;
    for (int i = 0; i < 4; i++) begin
      wr(SDLC_QUAD_CTL_OFS, i);
      wr(SDLC_TXL_CTL_OFS, i);
      ed[2*i+:2] = i[1:0];
      rchk(SDLC_TXL_CTL_OFS, i);
    end
    outs(ed, 8'h00);
    rchk(SDLC_QUAD_CTL_OFS, 32'h3);
  endtask

  task automatic t_sticky;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(SDLC_QUAD_CTL_OFS, 32'h3);
    rchk(SDLC_TXL_CTL_OFS, 32'h3);
    outs(8'hE4, 8'h00);
  endtask

  task automatic t_unmapped;
    wr(8'h40, 32'hFFFFFFFF);
    chk(rr, SDLC_RESP_SLVERR);
    rd(8'h40);
    chk(rr, SDLC_RESP_SLVERR);
    chk(rv, 32'h0);
  endtask

  // other lane registers, byte strobes, quad strobe gate
  task automatic t_other;
    wr(SDLC_TXL_CTL_SECOND_OFS, 32'h12345678);
    rchk(SDLC_TXL_CTL_SECOND_OFS, 32'h12345678);
    wr(SDLC_RXEQ_CTL_OFS, 32'h9ABCDEF0);
    rchk(SDLC_RXEQ_CTL_OFS, 32'h9ABCDEF0);
    wr(SDLC_RXL_CTL_OFS, 32'hA5A5A5A5);
    s_axi_wstrb <= 4'h2;
    wr(SDLC_RXL_CTL_OFS, 32'h00000000);
    rchk(SDLC_RXL_CTL_OFS, 32'hA5A500A5);
    s_axi_wstrb <= 4'hE;
    wr(SDLC_QUAD_CTL_OFS, 32'h00000030);
    s_axi_wstrb <= 4'hF;
    rchk(SDLC_QUAD_CTL_OFS, 32'h3);
  endtask

  task automatic t_power;
    int n;
    wr(SDLC_QUAD_CTL_OFS, 32'h30);
    cmu_ready <= 1'h0;
    settle;
    chk(clock_multiplier_unit_on, 1'h0);
    chk(ltssm_force_detect, 1'h1);
    rchk(SDLC_STATUS_OFS, 32'h8);
    wr(SDLC_QUAD_CTL_OFS, 32'h10);
    settle;
    chk(ltssm_force_detect, 1'h1);
    cmu_ready <= 1'h1;
    n = 0;
    while (ltssm_start_training !== 1'h1 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk(ltssm_start_training, 1'h1);
    settle;
    chk(clock_multiplier_unit_on, 1'h1);
    chk(ltssm_force_detect, 1'h0);
    quad_off_other <= 1'h1;
    settle;
    wr(SDLC_QUAD_CTL_OFS, 32'h30);
    settle;
    chk(clock_multiplier_unit_on, 1'h1);
    wr(SDLC_QUAD_CTL_OFS, 32'h10);
    quad_off_other <= 1'h0;
  endtask

  task automatic summarize;
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence after both resets
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    sticky_resetn <= 1'h1;
    @(posedge aclk);
    t_defaults;
    t_modes;
    t_lanes;
    t_sticky;
    t_unmapped;
    t_other;
    t_power;
    summarize;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge aclk);
    errors++;
    summarize;
  end
endmodule
`default_nettype wire
